// [design/cmac_pkg.sv]
// Constants, register map and status codes of the shared-medium MAC core.
// Assumes one sys_clk cycle equals one bit time on the medium.
// Summary of operation
// RULE1 - Frame built from client bytes plus pad, FCS
// RULE2 - CRC appended right after client fields
// RULE3 - Carrier watched always; busy medium holds transmission
// RULE4 - Defer full interframe gap after carrier drops
// RULE5 - Gap expiry with frame waiting transmits regardless
// RULE6 - Option: gap timed after transmit and carrier clear
// RULE7 - Option: carrier restarts gap only first two-thirds
// RULE8 - Gap may be longer, never shorter
// RULE9 - Slot time exceeds round trip plus jam
// RULE10 - On collision keep sending jam bits
// RULE11 - Jam never deliberately equals partial frame CRC
// RULE12 - Retry until success or attempt limit, report
// RULE13 - Finish current frame before next queued one
// RULE14 - Backoff r slots, r below two-power min(n,10)
// RULE15 - Random source decorrelated from other stations
// RULE16 - Extra retry delay allowed, never less
// RULE17 - Short frames padded with whole octets before FCS
// RULE18 - Accept frames to own individual address
// RULE19 - Accept frames to broadcast address
// RULE20 - Accept frames to active group addresses
// RULE21 - Received CRC mismatch marks frame invalid
// RULE22 - Accept after delimiter; deliver fields when error-free
// RULE23 - Send alternating preamble, delimiter; finish preamble on collision
// RULE24 - Receive starts only after delimiter following preamble
// RULE25 - Short received frames discarded silently
// RULE26 - Odd bit lengths truncated; bad CRC gives alignment error
// RULE27 - Standard 32-bit CRC in transmission order
// RULE28 - One transmit status per submitted frame
package cmac_pkg;
   localparam int CLK_PERIOD_NS = 100;
   localparam int IFS_TIME_NS = 9600;
   // Least time, so rounded up to whole cycles
   localparam int IFS_CYC = (IFS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [9:0] IFS_LEN = 10'(IFS_CYC);
   localparam logic [9:0] IFS_PART1 = 10'(IFS_CYC * 2 / 3);
   localparam logic [9:0] SLOT_BITS = 10'h200;
   localparam logic [5:0] JAM_LAST = 6'h1f;
   localparam logic [5:0] HDR_LAST = 6'h3f;
   localparam logic [5:0] FCS_LAST = 6'h1f;
   localparam logic [4:0] ATTEMPT_LIMIT = 5'h10;
   localparam logic [4:0] BACKOFF_LIMIT = 5'h0a;
   localparam logic [10:0] MIN_DATA = 11'h03c;
   localparam logic [10:0] MIN_FRAME = 11'h040;
   localparam logic [10:0] MAX_FRAME = 11'h5ee;
   localparam logic [9:0] SFD_PAT = 10'h355;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
   localparam logic [15:0] LFSR_SEED = 16'hace1;
   localparam int GRP_N = 2;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR_LO = 8'h04;
   localparam logic [7:0] REG_ADDR_HI = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_GRP_BASE = 8'h10;
   localparam int CTRL_OPT_BIT = 0;
   localparam int CTRL_EXTRA_LSB = 8;
   localparam int CTRL_GRP_LSB = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam logic [1:0] RX_OK = 2'h0;
   localparam logic [1:0] RX_LEN_ERR = 2'h1;
   localparam logic [1:0] RX_FCS_ERR = 2'h2;
   localparam logic [1:0] RX_ALIGN_ERR = 2'h3;
endpackage

// [design/cmac_core.sv]
// Shared-medium MAC core: transmit framing, deference, collision backoff,
// receive filtering and FCS check. One clock cycle is one bit time; PHY
// inputs are asynchronous and synchronised here before use.
`timescale 1ns/1ps
module cmac_core (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready,
   output logic tx_done,
   output logic tx_excess,
   output logic rx_done,
   output logic [1:0] rx_status,
   output logic [10:0] rx_len,
   input wire logic [10:0] rx_rd_addr,
   output logic [7:0] rx_rd_data,
   input wire logic phy_crs,
   input wire logic phy_col,
   input wire logic phy_rx_bit,
   output logic phy_tx_bit,
   output logic phy_tx_en
);

   typedef enum logic [2:0] {T_LOAD, T_DEFER, T_PRE, T_DATA, T_FCS, T_JAM, T_BACK} cmac_tx_t;
   typedef enum logic {R_HUNT, R_DATA} cmac_rx_t;

   cmac_tx_t st_r;
   cmac_rx_t rst_r;
   logic [7:0] tbuf [0:2047];
   logic [7:0] rbuf [0:2047];
   logic [1:0] crs_m, col_m, rxb_m;
   logic crs_s, col_s, rxb_s;
   logic [31:0] ctrl_r, sta_lo_r, rdata_r;
   logic [15:0] sta_hi_r;
   logic [31:0] grp_lo_r [0:cmac_pkg::GRP_N-1];
   logic [15:0] grp_hi_r [0:cmac_pkg::GRP_N-1];
   logic [10:0] tlen_r, pos_r;
   logic [2:0] bit_r;
   logic [5:0] cnt_r;
   logic [31:0] crc_r;
   logic [4:0] att_r;
   logic col_seen_r;
   logic [9:0] slots_r, bo_bit_r, gap_r;
   logic [15:0] lfsr_r;
   logic tx_bit_r, tx_en_r, done_r, excess_r;
   logic [9:0] sh_r;
   logic [13:0] nb_r;
   logic [7:0] byte_r;
   logic [47:0] da_r;
   logic [31:0] rcrc_r, rcrc_oct_r;
   logic rx_done_r;
   logic [1:0] rx_status_r;
   logic [10:0] rx_len_r;
   logic [7:0] rx_rd_data_r;
   logic cur_bit, out_bit, last_byte, tx_busy, gap_done, addr_ok;
   logic [9:0] ifs_len, part1;
   logic [10:0] octs;

   // Reflected CRC-32, one bit per call in wire order
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic d);
      crc_step = {1'b0, c[31:1]} ^ ((c[0] ^ d) ? cmac_pkg::CRC_POLY : 32'h0);
   endfunction

   // Mask of min(n,10) low ones for the backoff draw
   function automatic logic [9:0] bo_mask(input logic [4:0] n);
      logic [4:0] k;
      k = (n > cmac_pkg::BACKOFF_LIMIT) ? cmac_pkg::BACKOFF_LIMIT : n;
      for (int i = 0; i < 10; i++) begin
         bo_mask[i] = (5'(i) < k);
      end
   endfunction

   // Two-stage synchronisers; only the second stage is read
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         crs_m <= 2'h0;
         col_m <= 2'h0;
         rxb_m <= 2'h0;
      end else begin
         crs_m <= {crs_m[0], phy_crs};
         col_m <= {col_m[0], phy_col};
         rxb_m <= {rxb_m[0], phy_rx_bit};
      end
   end
   assign crs_s = crs_m[1];
   assign col_s = col_m[1];
   assign rxb_s = rxb_m[1];

   // Register writes
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= cmac_pkg::CTRL_RESET;
         sta_lo_r <= 32'h0;
         sta_hi_r <= 16'h0;
         for (int i = 0; i < cmac_pkg::GRP_N; i++) begin
            grp_lo_r[i] <= 32'h0;
            grp_hi_r[i] <= 16'h0;
         end
      end else if (reg_wr) begin
         if (reg_addr == cmac_pkg::REG_CTRL) ctrl_r <= reg_wdata;
         if (reg_addr == cmac_pkg::REG_ADDR_LO) sta_lo_r <= reg_wdata;
         if (reg_addr == cmac_pkg::REG_ADDR_HI) sta_hi_r <= reg_wdata[15:0];
         for (int i = 0; i < cmac_pkg::GRP_N; i++) begin
            if (reg_addr == cmac_pkg::REG_GRP_BASE + 8'(8 * i)) grp_lo_r[i] <= reg_wdata;
            if (reg_addr == cmac_pkg::REG_GRP_BASE + 8'(8 * i + 4)) grp_hi_r[i] <= reg_wdata[15:0];
         end
      end
   end

   // Register reads: data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 32'h0;
      end else begin
         rdata_r <= 32'h0;
         if (reg_rd) begin
            if (reg_addr == cmac_pkg::REG_CTRL) rdata_r <= ctrl_r;
            if (reg_addr == cmac_pkg::REG_ADDR_LO) rdata_r <= sta_lo_r;
            if (reg_addr == cmac_pkg::REG_ADDR_HI) rdata_r <= {16'h0, sta_hi_r};
            if (reg_addr == cmac_pkg::REG_STATUS) begin
               rdata_r <= {5'h0, rx_len_r, 4'h0, rx_status_r, 1'b0, att_r, excess_r, st_r};
            end
            for (int i = 0; i < cmac_pkg::GRP_N; i++) begin
               if (reg_addr == cmac_pkg::REG_GRP_BASE + 8'(8 * i)) rdata_r <= grp_lo_r[i];
               if (reg_addr == cmac_pkg::REG_GRP_BASE + 8'(8 * i + 4)) rdata_r <= {16'h0, grp_hi_r[i]};
            end
         end
      end
   end
   assign reg_rdata = rdata_r;

   // Gap length: software may only lengthen it [RULE8]
   assign ifs_len = cmac_pkg::IFS_LEN + {2'h0, ctrl_r[cmac_pkg::CTRL_EXTRA_LSB +: 8]};
   assign part1 = ctrl_r[cmac_pkg::CTRL_OPT_BIT] ? cmac_pkg::IFS_PART1 : ifs_len;
   assign tx_busy = (st_r inside {T_PRE, T_DATA, T_FCS, T_JAM}) | tx_en_r;
   assign gap_done = (gap_r == ifs_len);

   // Deference timer; runs even with nothing queued [RULE3]
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_r <= 10'h0;
      end else if (tx_busy) begin
         gap_r <= 10'h0; // Gap starts once own transmit and carrier are clear [RULE6]
      end else if (crs_s && (gap_r < part1 || (gap_done && st_r != T_DEFER))) begin
         gap_r <= 10'h0; // Late carrier cannot reset, keeps access fair [RULE7] [RULE4]
      end else if (!gap_done) begin
         gap_r <= gap_r + 10'h1;
      end
   end

   // Random source mixes medium noise so stations diverge [RULE15]
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         lfsr_r <= cmac_pkg::LFSR_SEED;
      end else begin
         lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10] ^ rxb_s ^ sta_lo_r[0]};
      end
   end

   // Transmit frame store; client holds off until status returns [RULE13]
   always_ff @(posedge sys_clk) begin
      if (tx_valid && tx_ready) tbuf[tlen_r] <= tx_data;
   end
   assign tx_ready = (st_r == T_LOAD) && (tlen_r != 11'h7ff);

   // Client bytes then zero pad up to minimum length [RULE1] [RULE17]
   assign cur_bit = (pos_r < tlen_r) ? tbuf[pos_r][bit_r] : 1'b0;
   assign last_byte = (pos_r >= tlen_r - 11'h1) && (pos_r >= cmac_pkg::MIN_DATA - 11'h1);

   // Transmit sequencer
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= T_LOAD;
         tlen_r <= 11'h0;
         pos_r <= 11'h0;
         bit_r <= 3'h0;
         cnt_r <= 6'h0;
         crc_r <= 32'hffff_ffff;
         att_r <= 5'h0;
         col_seen_r <= 1'b0;
         slots_r <= 10'h0;
         bo_bit_r <= 10'h0;
         done_r <= 1'b0;
         excess_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         case (st_r)
            T_LOAD: begin
               if (tx_valid && tx_ready) begin
                  tlen_r <= tlen_r + 11'h1;
                  if (tx_last) begin
                     st_r <= T_DEFER;
                     att_r <= 5'h0;
                  end
               end
            end
            T_DEFER: begin
               if (gap_done) begin // Starts whatever the carrier now shows [RULE5]
                  st_r <= T_PRE;
                  cnt_r <= 6'h0;
                  crc_r <= 32'hffff_ffff;
                  col_seen_r <= 1'b0;
                  att_r <= att_r + 5'h1;
               end
            end
            T_PRE: begin
               cnt_r <= cnt_r + 6'h1;
               if (col_s) col_seen_r <= 1'b1;
               if (cnt_r == cmac_pkg::HDR_LAST) begin // Preamble finished even on collision [RULE23]
                  st_r <= (col_s || col_seen_r) ? T_JAM : T_DATA;
                  cnt_r <= 6'h0;
                  pos_r <= 11'h0;
                  bit_r <= 3'h0;
               end
            end
            T_DATA: begin
               crc_r <= crc_step(crc_r, cur_bit); // [RULE27]
               bit_r <= bit_r + 3'h1;
               if (bit_r == 3'h7) pos_r <= pos_r + 11'h1;
               if (col_s) begin
                  st_r <= T_JAM; // Jam counted from collision onset [RULE10]
                  cnt_r <= 6'h0;
               end else if (bit_r == 3'h7 && last_byte) begin
                  st_r <= T_FCS; // FCS follows the padded fields [RULE2]
                  cnt_r <= 6'h0;
               end
            end
            T_FCS: begin
               crc_r <= {1'b1, crc_r[31:1]};
               cnt_r <= cnt_r + 6'h1;
               if (col_s) begin
                  st_r <= T_JAM; // [RULE10]
                  cnt_r <= 6'h0;
               end else if (cnt_r == cmac_pkg::FCS_LAST) begin
                  st_r <= T_LOAD; // One status per frame [RULE28]
                  tlen_r <= 11'h0;
                  done_r <= 1'b1;
                  excess_r <= 1'b0;
               end
            end
            T_JAM: begin
               cnt_r <= cnt_r + 6'h1;
               if (cnt_r == cmac_pkg::JAM_LAST) begin
                  if (att_r == cmac_pkg::ATTEMPT_LIMIT) begin
                     st_r <= T_LOAD; // Give up and report [RULE12] [RULE28]
                     tlen_r <= 11'h0;
                     done_r <= 1'b1;
                     excess_r <= 1'b1;
                  end else begin
                     st_r <= T_BACK; // Draw r below 2^min(n,10) [RULE14]
                     slots_r <= lfsr_r[9:0] & bo_mask(att_r);
                     bo_bit_r <= 10'h0;
                  end
               end
            end
            T_BACK: begin
               // Whole slots, then wait out the gap timed from the jam end: never shorter [RULE16] [RULE9]
               if (slots_r == 10'h0) begin
                  st_r <= T_DEFER;
               end else if (bo_bit_r == cmac_pkg::SLOT_BITS - 10'h1) begin
                  bo_bit_r <= 10'h0;
                  slots_r <= slots_r - 10'h1;
               end else begin
                  bo_bit_r <= bo_bit_r + 10'h1;
               end
            end
            default: st_r <= T_LOAD;
         endcase
      end
   end

   // Wire bit of the present state; jam alternates so it is no CRC [RULE11]
   always_comb begin
      case (st_r)
         T_PRE: out_bit = (cnt_r == cmac_pkg::HDR_LAST) | ~cnt_r[0]; // [RULE23]
         T_DATA: out_bit = cur_bit;
         T_FCS: out_bit = ~crc_r[0];
         T_JAM: out_bit = ~cnt_r[0];
         default: out_bit = 1'b0;
      endcase
   end

   // Line drivers, one cycle behind the sequencer
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_bit_r <= 1'b0;
         tx_en_r <= 1'b0;
      end else begin
         tx_bit_r <= out_bit;
         tx_en_r <= st_r inside {T_PRE, T_DATA, T_FCS, T_JAM};
      end
   end
   assign phy_tx_bit = tx_bit_r;
   assign phy_tx_en = tx_en_r;
   assign tx_done = done_r;
   assign tx_excess = excess_r;

   // Destination filter: own, broadcast, active group [RULE18] [RULE19] [RULE20]
   always_comb begin
      addr_ok = (da_r == {sta_hi_r, sta_lo_r}) || (da_r == 48'hffff_ffff_ffff);
      for (int i = 0; i < cmac_pkg::GRP_N; i++) begin
         if (ctrl_r[cmac_pkg::CTRL_GRP_LSB + i] && da_r == {grp_hi_r[i], grp_lo_r[i]}) addr_ok = 1'b1;
      end
   end
   assign octs = nb_r[13:3]; // Trailing odd bits dropped [RULE26]

   // Receive sequencer; buffer is reused, so client must read before the next frame's first byte arrives
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_r <= R_HUNT;
         sh_r <= 10'h0;
         nb_r <= 14'h0;
         byte_r <= 8'h0;
         da_r <= 48'h0;
         rcrc_r <= 32'hffff_ffff;
         rcrc_oct_r <= 32'hffff_ffff;
         rx_done_r <= 1'b0;
         rx_status_r <= cmac_pkg::RX_OK;
         rx_len_r <= 11'h0;
      end else begin
         rx_done_r <= 1'b0;
         case (rst_r)
            R_HUNT: begin
               sh_r <= crs_s ? {rxb_s, sh_r[9:1]} : 10'h0;
               if (crs_s && {rxb_s, sh_r[9:1]} == cmac_pkg::SFD_PAT) begin // [RULE24] [RULE22]
                  rst_r <= R_DATA;
                  nb_r <= 14'h0;
                  rcrc_r <= 32'hffff_ffff;
                  rcrc_oct_r <= 32'hffff_ffff;
               end
            end
            R_DATA: begin
               if (crs_s) begin
                  if (nb_r != 14'h3fff) nb_r <= nb_r + 14'h1;
                  rcrc_r <= crc_step(rcrc_r, rxb_s); // [RULE21]
                  byte_r <= {rxb_s, byte_r[7:1]};
                  if (nb_r < 14'h0030) da_r <= {rxb_s, da_r[47:1]};
                  if (nb_r[2:0] == 3'h7) rcrc_oct_r <= crc_step(rcrc_r, rxb_s);
               end else begin
                  rst_r <= R_HUNT;
                  sh_r <= 10'h0;
                  // Fragments vanish without status [RULE25]
                  if (octs >= cmac_pkg::MIN_FRAME && addr_ok) begin
                     rx_done_r <= 1'b1;
                     rx_len_r <= octs;
                     if (octs > cmac_pkg::MAX_FRAME) rx_status_r <= cmac_pkg::RX_LEN_ERR;
                     else if (rcrc_oct_r != cmac_pkg::CRC_RESIDUE) begin // [RULE21] [RULE26]
                        rx_status_r <= (nb_r[2:0] != 3'h0) ? cmac_pkg::RX_ALIGN_ERR : cmac_pkg::RX_FCS_ERR;
                     end else rx_status_r <= cmac_pkg::RX_OK;
                  end
               end
            end
            default: rst_r <= R_HUNT;
         endcase
      end
   end

   // Receive store and client read port
   always_ff @(posedge sys_clk) begin
      if (rst_r == R_DATA && crs_s && nb_r[2:0] == 3'h7) rbuf[nb_r[13:3]] <= {rxb_s, byte_r[7:1]};
      rx_rd_data_r <= rbuf[rx_rd_addr];
   end
   assign rx_rd_data = rx_rd_data_r;
   assign rx_done = rx_done_r;
   assign rx_status = rx_status_r;
   assign rx_len = rx_len_r;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   a_tx_one_frame: assert property ($rose(tx_ready) |-> tx_done) // [RULE13]
      else $error("transmit reopened before the frame status was given");
   a_start_after_gap: assert property (st_r == T_DEFER && !gap_done |=> st_r == T_DEFER) // [RULE4]
      else $error("transmission began before the gap expired");
   a_pre_first_one: assert property ($rose(phy_tx_en) |-> phy_tx_bit) // [RULE23]
      else $error("preamble does not open with a one");
   a_jam_onset: assert property (st_r == T_DATA && col_s |=> st_r == T_JAM && cnt_r == 6'h0) // [RULE10]
      else $error("collision did not start the jam");
   a_jam_end: assert property (st_r == T_JAM && cnt_r == cmac_pkg::JAM_LAST |=> st_r != T_JAM) // [RULE10]
      else $error("jam length wrong");
   a_excess_limit: assert property (tx_done && tx_excess |-> att_r == cmac_pkg::ATTEMPT_LIMIT) // [RULE12]
      else $error("excess collision reported before the limit");
   a_backoff_range: assert property ($rose(st_r == T_BACK) |-> (slots_r & ~bo_mask($past(att_r))) == 10'h0) // [RULE14]
      else $error("backoff draw out of range");
   a_gap_no_reset: assert property (ctrl_r[0] && !tx_busy && gap_r >= part1 && !gap_done // [RULE7]
      |=> gap_r == $past(gap_r) + 10'h1)
      else $error("gap timer reset in its final third");
   a_pad_min: assert property (st_r == T_DATA ##1 st_r == T_FCS |-> pos_r >= cmac_pkg::MIN_DATA) // [RULE17]
      else $error("frame shorter than minimum before FCS");
   a_frag_silent: assert property (rx_done |-> rx_len >= cmac_pkg::MIN_FRAME) // [RULE25]
      else $error("fragment reported to client");
endmodule

// [sim/cmac_phy_model.sv]
// Far-side stand-in: carrier sense, collision detect and serial receive bits.
// Assumes sys_clk is the bit clock; every output changes just after a rising edge.
`timescale 1ns/1ps
module cmac_phy_model (
   input wire logic sys_clk,
   input wire logic tx_en,
   output logic crs,
   output logic col,
   output logic rx_bit
);
   logic busy;
   logic rxing;
   // Own transmission is heard as carrier, as on a real shared medium
   assign crs = busy | rxing | tx_en;
   initial begin
      busy = 1'b0;
      rxing = 1'b0;
      col = 1'b0;
      rx_bit = 1'b0;
   end
   // Idle line toggles so a stale bit never passes for data
   always @(posedge sys_clk) begin
      if (!rxing) begin
         rx_bit <= ~rx_bit;
      end
   end
   // Carrier rises one cycle early to keep the two drivers of rx_bit apart
   task automatic send(input logic [7:0] fr [0:71], input int n);
      logic [7:0] b;
      @(posedge sys_clk);
      rxing <= 1'b1;
      for (int i = -8; i < n; i++) begin
         b = (i < -1) ? 8'h55 : ((i == -1) ? 8'hd5 : fr[i]);
         for (int k = 0; k < 8; k++) begin
            @(posedge sys_clk);
            rx_bit <= b[k]; // Least significant bit first
         end
      end
      @(posedge sys_clk);
      rxing <= 1'b0;
   endtask
   task automatic collide(input int n);
      @(posedge sys_clk);
      col <= 1'b1;
      repeat (n) @(posedge sys_clk);
      col <= 1'b0;
   endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the MAC core: registers, receive filter, transmit path.
// Assumes the design and its package are compiled first; one cycle is one bit.
`timescale 1ns/1ps
module tb_top;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic tx_valid = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic tx_last = 1'b0;
   logic tx_ready, tx_done, tx_excess, rx_done;
   logic [1:0] rx_status;
   logic [10:0] rx_len;
   logic [10:0] rx_rd_addr = 11'h0;
   logic [7:0] rx_rd_data;
   logic phy_crs, phy_col, phy_rx_bit, phy_tx_bit, phy_tx_en;
   logic txq [$];
   int error_cnt = 0;
   int n_compared = 0;
   always #50 sys_clk = ~sys_clk;
   cmac_core u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_last(tx_last), .tx_ready(tx_ready), .tx_done(tx_done), .tx_excess(tx_excess), .rx_done(rx_done),
      .rx_status(rx_status), .rx_len(rx_len), .rx_rd_addr(rx_rd_addr), .rx_rd_data(rx_rd_data),
      .phy_crs(phy_crs), .phy_col(phy_col), .phy_rx_bit(phy_rx_bit), .phy_tx_bit(phy_tx_bit),
      .phy_tx_en(phy_tx_en));
   cmac_phy_model u_phy (.sys_clk(sys_clk), .tx_en(phy_tx_en), .crs(phy_crs), .col(phy_col),
      .rx_bit(phy_rx_bit));
   // Line monitor: registered bit and enable are sampled together
   always @(posedge sys_clk) begin
      if (phy_tx_en === 1'b1) begin
         txq.push_back(phy_tx_bit);
      end
   end
   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Reflected CRC step, bits in line order
   function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
      return (c[0] ^ b) ? ((c >> 1) ^ cmac_pkg::CRC_POLY) : (c >> 1);
   endfunction
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input string name);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      check(name, reg_rdata, exp);
   endtask
   // One received frame: DA, filler bytes, correct or spoiled FCS
   task automatic rx_case(input logic [47:0] da, input int n, input logic bad, input logic exp_done,
      input logic [1:0] exp_st);
      logic [7:0] fr [0:71];
      logic [31:0] c;
      logic seen;
      c = 32'hffffffff;
      seen = 1'b0;
      for (int i = 0; i < n - 4; i++) begin
         fr[i] = (i < 6) ? da[8*i+:8] : 8'(i + 3);
         for (int k = 0; k < 8; k++) c = crc_step(c, fr[i][k]);
      end
      c = ~c;
      for (int i = 0; i < 4; i++) fr[n-4+i] = c[8*i+:8];
      fr[n-1] = fr[n-1] ^ {7'h0, bad};
      u_phy.send(fr, n);
      repeat (8) begin
         @(posedge sys_clk);
         seen = seen | (rx_done === 1'b1);
      end
      check("rx_done", seen, exp_done);
      if (exp_done) begin
         check("rx_status", rx_status, exp_st);
         check("rx_len", rx_len, 11'(n));
         rx_rd_addr <= 11'h0;
         repeat (2) @(posedge sys_clk);
         check("rx first byte", rx_rd_data, da[7:0]);
      end
   endtask
   // One-byte frame, optionally hit by a collision during the data field
   task automatic tx_case(input logic col_hit);
      logic [63:0] hdr;
      logic [31:0] c;
      int t;
      int ncol;
      txq.delete();
      u_phy.busy <= 1'b1;
      repeat (4) @(posedge sys_clk); // Carrier must clear the synchroniser before the request
      tx_valid <= 1'b1;
      tx_data <= 8'hc3;
      tx_last <= 1'b1;
      do @(posedge sys_clk); while (tx_ready !== 1'b1);
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      repeat (200) @(posedge sys_clk);
      check("busy medium", txq.size(), 0);
      check("tx_ready held", tx_ready, 1'b0);
      u_phy.busy <= 1'b0;
      t = 0;
      while (phy_tx_en !== 1'b1 && t < 400) begin
         @(posedge sys_clk);
         t++;
      end
      check("gap kept", t >= 96 && t < 400, 1'b1);
      if (col_hit) begin
         repeat (100) @(posedge sys_clk);
         ncol = txq.size();
         u_phy.collide(3);
         t = 0;
         while (phy_tx_en === 1'b1 && t < 100) begin
            @(posedge sys_clk);
            t++;
         end
         // Sync delay of the collision input widens the window slightly
         check("jam length", txq.size() - ncol >= 32 && txq.size() - ncol <= 40, 1'b1);
         txq.delete();
      end
      t = 0;
      while (tx_done !== 1'b1 && t < 3000) begin
         @(posedge sys_clk);
         t++;
      end
      check("tx_done seen", t < 3000, 1'b1);
      repeat (2) @(posedge sys_clk);
      check("tx_excess", tx_excess, 1'b0);
      check("frame bits", txq.size(), 576);
      for (int i = 0; i < 64; i++) hdr[i] = txq[i];
      check("header", hdr, 64'hd555555555555555);
      check("client byte", {txq[71], txq[70], txq[69], txq[68], txq[67], txq[66], txq[65], txq[64]},
         8'hc3);
      c = 32'hffffffff;
      for (int i = 64; i < 576; i++) c = crc_step(c, txq[i]);
      check("fcs residue", c, 32'hdebb20e3);
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      reg_read(cmac_pkg::REG_CTRL, cmac_pkg::CTRL_RESET, "ctrl reset");
      reg_read(8'h40, 32'h0, "unmapped read");
      reg_write(cmac_pkg::REG_ADDR_LO, 32'h67452312);
      reg_write(cmac_pkg::REG_ADDR_HI, 32'h000089ab);
      reg_read(cmac_pkg::REG_ADDR_LO, 32'h67452312, "addr lo");
      reg_write(cmac_pkg::REG_GRP_BASE, 32'h005e0001);
      reg_write(cmac_pkg::REG_GRP_BASE + 8'h04, 32'h00000100);
      reg_write(cmac_pkg::REG_CTRL, 32'h00010001);
      rx_case(48'h89ab67452312, 64, 1'b0, 1'b1, cmac_pkg::RX_OK);
      rx_case(48'hffffffffffff, 64, 1'b0, 1'b1, cmac_pkg::RX_OK);
      rx_case(48'h0100005e0001, 64, 1'b0, 1'b1, cmac_pkg::RX_OK);
      reg_write(cmac_pkg::REG_CTRL, 32'h00000001);
      rx_case(48'h0100005e0001, 64, 1'b0, 1'b0, cmac_pkg::RX_OK);
      rx_case(48'h89ab67452312, 20, 1'b0, 1'b0, cmac_pkg::RX_OK);
      rx_case(48'h89ab67452312, 64, 1'b1, 1'b1, cmac_pkg::RX_FCS_ERR);
      reg_read(cmac_pkg::REG_STATUS, 32'h0040_0800, "status");
      tx_case(1'b0);
      tx_case(1'b1);
      stop_test();
   end
endmodule
